// ### rtl/dbm_map.svh
/*
  Constants of the debug signal output multiplexer: bus offsets, group codes,
  signal codes, pin codes and reset values.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef DBM_MAP_SVH
`define DBM_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define DBM_OFF_DIGITAL 4'h0
`define DBM_OFF_ANALOG 4'h4
`define DBM_OFF_ENABLE 4'h8
`define DBM_OFF_STATUS 4'hC
`define DBM_ADDR_W 4

// AXI response codes
`define DBM_RESP_OKAY 2'h0
`define DBM_RESP_SLVERR 2'h2

// Group select codes
`define DBM_GRP_CLOCK 8'h01
`define DBM_GRP_TX_ENC 8'h1B
`define DBM_GRP_TIMER 8'h1D
`define DBM_GRP_CARD 8'h30
`define DBM_GRP_TRANSCEIVE 8'h58
`define DBM_GRP_RX_DATA 8'h70
`define DBM_GRP_RX_ERROR 8'h73

// Signal code that outputs the carrier clock in every group
`define DBM_SIG_CARRIER 4'h8

// Pin codes in the high nibble of the pin select byte
`define DBM_PIN_PRIMARY 4'h0
`define DBM_PIN_GPO 4'h1
`define DBM_PIN_AUX_SECOND 4'h2
`define DBM_PIN_AUX_FIRST 4'h3
`define DBM_PIN_COUNT 4

// Reset values
`define DBM_RST_GROUP 8'h00
`define DBM_RST_SELECT 8'h00
`define DBM_RST_ANALOG 16'h0000
`define DBM_RST_ENABLE 1'h0

`endif

// ### rtl/dbm_pkg.sv
/*
  Types of the debug signal output multiplexer.
  Assumes dbm_map.svh for all numeric constants.
*/
package dbm_pkg;

  // Internal digital sources grouped by debug signal group
  typedef struct packed {
    logic carrier_13m56;
    logic clk_mux_13m56;
    logic clk_mux_27m12;
    logic clk_rec_27m12;
    logic clk_pll_27m12;
    logic clk_osc_20m;
    logic field_present;
    logic pll_locked;
    logic rf_core_reset;
    logic tx_irq;
    logic tx_envelope;
    logic [2:0] timer_running;
    logic [2:0] timer_expired;
    logic card_clock_fail;
    logic card_miller_det;
    logic card_212_det;
    logic card_424_det;
    logic card_nrz_det;
    logic card_eof_det;
    logic card_emulation_data;
    logic card_data_valid;
    logic trx_prefetch_done;
    logic trx_prefetch_req;
    logic trx_tx_start;
    logic trx_rx_enable;
    logic trx_wait_expired;
    logic [2:0] trx_state;
    logic sp_collision;
    logic sp_end_of_data;
    logic sp_data_valid;
    logic sp_rx_data;
    logic rx_active;
    logic rx_receiving;
    logic rx_chain_reset;
    logic decoder_bit_clock;
    logic err_combined;
    logic err_multi_frame_long;
    logic err_collision;
    logic err_protocol;
    logic err_integrity;
  } dbm_sources_s;

  // Per-pin routing: the signal code and the group code latched for it
  typedef struct packed {
    logic [7:0] group;
    logic [3:0] signal;
    logic valid;
  } dbm_route_s;

  // AXI4-Lite slave side outputs
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dbm_axi_out_s;

  // Two analog source selectors
  typedef struct packed {
    logic [7:0] dac_second;
    logic [7:0] dac_first;
  } dbm_analog_s;

endpackage

// ### rtl/dbm_signal_pick.sv
/*
  Picks one internal signal from its group code and signal code.
  Assumes sources are synchronous to clk; output is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbm_map.svh"

module dbm_signal_pick
  import dbm_pkg::*;
(
  input wire dbm_sources_s src,
  input wire logic [7:0] group,
  input wire logic [3:0] signal,
  output logic value,
  output logic known
);

  // Group and code decode; reserved codes give low and not known
  always_comb
  begin
    value = 1'b0;
    known = 1'b1;
    if (signal == `DBM_SIG_CARRIER)
    begin
      value = src.carrier_13m56;
      known = (group == `DBM_GRP_CLOCK) || (group == `DBM_GRP_TX_ENC) || (group == `DBM_GRP_TIMER) ||
              (group == `DBM_GRP_CARD) || (group == `DBM_GRP_TRANSCEIVE) ||
              (group == `DBM_GRP_RX_DATA) || (group == `DBM_GRP_RX_ERROR);
      if (!known)
        value = 1'b0;
    end
    else if (signal > `DBM_SIG_CARRIER)
      known = 1'b0;
    else
    begin
      case (group)
        `DBM_GRP_CLOCK:
        begin
          case (signal[2:0])
            3'h0: value = src.clk_mux_13m56;
            3'h1: value = src.clk_mux_27m12;
            3'h2: value = src.clk_rec_27m12;
            3'h3: value = src.clk_pll_27m12;
            3'h4: value = src.clk_osc_20m;
            3'h5: value = src.field_present;
            3'h6: value = src.pll_locked;
            default: value = src.rf_core_reset;
          endcase
        end
        `DBM_GRP_TX_ENC:
        begin
          case (signal[2:0])
            3'h0: value = src.tx_irq;
            3'h1: value = src.tx_envelope;
            default: known = 1'b0;
          endcase
        end
        `DBM_GRP_TIMER:
        begin
          case (signal[2:0])
            3'h7: value = src.timer_running[0];
            3'h6: value = src.timer_expired[0];
            3'h5: value = src.timer_running[1];
            3'h4: value = src.timer_expired[1];
            3'h3: value = src.timer_running[2];
            3'h2: value = src.timer_expired[2];
            default: known = 1'b0;
          endcase
        end
        `DBM_GRP_CARD:
        begin
          case (signal[2:0])
            3'h7: value = src.card_clock_fail;
            3'h6: value = src.card_miller_det;
            3'h5: value = src.card_212_det;
            3'h4: value = src.card_424_det;
            3'h3: value = src.card_nrz_det;
            3'h2: value = src.card_eof_det;
            3'h1: value = src.card_emulation_data;
            default: value = src.card_data_valid;
          endcase
        end
        `DBM_GRP_TRANSCEIVE:
        begin
          case (signal[2:0])
            3'h7: value = src.trx_prefetch_done;
            3'h6: value = src.trx_prefetch_req;
            3'h5: value = src.trx_tx_start;
            3'h4: value = src.trx_rx_enable;
            3'h3: value = src.trx_wait_expired;
            3'h2: value = src.trx_state[2];
            3'h1: value = src.trx_state[1];
            default: value = src.trx_state[0];
          endcase
        end
        `DBM_GRP_RX_DATA:
        begin
          case (signal[2:0])
            3'h7: value = src.sp_collision;
            3'h6: value = src.sp_end_of_data;
            3'h5: value = src.sp_data_valid;
            3'h4: value = src.sp_rx_data;
            3'h3: value = src.rx_active;
            3'h2: value = src.rx_receiving;
            3'h1: value = src.rx_chain_reset;
            default: value = src.decoder_bit_clock;
          endcase
        end
        `DBM_GRP_RX_ERROR:
        begin
          case (signal[2:0])
            3'h7: value = src.err_combined;
            3'h6: value = src.err_multi_frame_long;
            3'h2: value = src.err_collision;
            3'h1: value = src.err_protocol;
            3'h0: value = src.err_integrity;
            default: known = 1'b0;
          endcase
        end
        default: known = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/dbm_debug_mux.sv
/*
  Debug signal output multiplexer: routes one internal signal per debug pin,
  chosen by digital configuration commands, and holds two analog source
  selectors for the converters. Registers over AXI4-Lite.
  Assumes one clock clk (200 MHz), asynchronous active-low reset_n, sources
  synchronous to clk, and a nonvolatile enable level that is static.
*/
// Summary of operation
// - Digital command: group byte, then byte with signal low nibble, pin high nibble.
// - Group codes 01,1B,1D,30,58,70,73 select the seven signal groups.
// - Routing active only while nonvolatile test-bus enable at location 17 is set.
// - Code 8 gives the carrier clock in every group; 9 to 15 reserved.
// - Clock group codes 0 to 4 give the five internal clocks.
// - Clock group 5 field present, 6 PLL lock, 7 RF core reset.
// - Transmit group 0 interrupt request, 1 envelope; 2 to 7 reserved.
// - Timer group 7..2: running and expired flags of timers zero, one, two.
// - Card group 6..3: Miller, 212, 424 Manchester and NRZ detection flags.
// - Card group 7 clock fail, 2 end of frame, 1 data, 0 valid.
// - Transceive 7 prefetch done, 6 prefetch request, 5 tx start, 4 rx enable.
// - Transceive 3 waiting time expired, 2..0 state machine bits.
// - Receiver data 7..4: processor collision, end, valid, received data.
// - Receiver data 3 rx active, 2 receiving, 1 chain reset, 0 bit clock.
// - Receiver error 7 combined, 6 long multi-frame, 2..0 collision, protocol, integrity.
// - Pin nibble: 0 primary, 1 general purpose, 2 second aux, 3 first aux.
// - Two analog outputs on auxiliary pins, each from one internal converter.
// - Analog command parameters choose the converter sources; device routes them.
`timescale 1ns/1ps
`default_nettype none
`include "dbm_map.svh"

module dbm_debug_mux
  import dbm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`DBM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DBM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nv_testbus_enable,
  input wire dbm_sources_s sources,
  output logic [`DBM_PIN_COUNT-1:0] debug_pin_out,
  output logic [`DBM_PIN_COUNT-1:0] debug_pin_oe,
  output logic [7:0] analog_source_first,
  output logic [7:0] analog_source_second,
  output logic [1:0] analog_enable
);

  typedef struct packed {
    dbm_axi_out_s axi;
    logic aw_held;
    logic [`DBM_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] en_sync;
    logic [7:0] last_group;
    logic [7:0] last_select;
    dbm_route_s [`DBM_PIN_COUNT-1:0] route;
    dbm_analog_s analog;
    logic [`DBM_PIN_COUNT-1:0] pin_out;
    logic [`DBM_PIN_COUNT-1:0] pin_oe;
    logic [1:0] ana_en;
  } dbm_state_s;

  dbm_state_s state_q;
  dbm_state_s state_d;
  logic [`DBM_PIN_COUNT-1:0] pick_value;
  logic [`DBM_PIN_COUNT-1:0] pick_known;
  logic testbus_on;
  logic [3:0] pin_code;

  assign testbus_on = state_q.en_sync[1];

  // One signal picker per debug pin
  genvar gi;
  generate
    for (gi = 0; gi < `DBM_PIN_COUNT; gi = gi + 1)
    begin : g_pick
      dbm_signal_pick u_pick (
        .src(sources),
        .group(state_q.route[gi].group),
        .signal(state_q.route[gi].signal),
        .value(pick_value[gi]),
        .known(pick_known[gi])
      );
    end
  endgenerate

  // Bus handshake, command decode and pin drive
  always_comb
  begin
    state_d = state_q;
    pin_code = 4'h0;
    state_d.en_sync = {state_q.en_sync[0], nv_testbus_enable};
    state_d.axi.awready = 1'b0;
    state_d.axi.wready = 1'b0;
    state_d.axi.arready = 1'b0;
    // Take address and data separately in either order
    if (s_axi_awvalid && !state_q.aw_held && !state_q.axi.awready && !state_q.axi.bvalid)
    begin
      state_d.axi.awready = 1'b1;
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_q.w_held && !state_q.axi.wready && !state_q.axi.bvalid)
    begin
      state_d.axi.wready = 1'b1;
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (state_q.axi.bvalid && s_axi_bready)
      state_d.axi.bvalid = 1'b0;
    // Perform the write once both halves are held
    if (state_q.aw_held && state_q.w_held && !state_q.axi.bvalid)
    begin
      state_d.aw_held = 1'b0;
      state_d.w_held = 1'b0;
      state_d.axi.bvalid = 1'b1;
      state_d.axi.bresp = `DBM_RESP_OKAY;
      case (state_q.aw_addr)
        `DBM_OFF_DIGITAL:
        begin
          // Byte 0 group, byte 1 pin select; only the byte 1 lane commits the command
          if (state_q.w_strb[0])
            state_d.last_group = state_q.w_data[7:0];
          if (state_q.w_strb[1])
          begin
            state_d.last_select = state_q.w_data[15:8];
            pin_code = state_q.w_data[15:12];
            if (pin_code < 4'(`DBM_PIN_COUNT))
            begin
              state_d.route[pin_code[1:0]].group = state_d.last_group;
              state_d.route[pin_code[1:0]].signal = state_q.w_data[11:8];
              state_d.route[pin_code[1:0]].valid = 1'b1;
            end
            else
              state_d.axi.bresp = `DBM_RESP_SLVERR;
          end
        end
        `DBM_OFF_ANALOG:
        begin
          if (state_q.w_strb[0])
            state_d.analog.dac_first = state_q.w_data[7:0];
          if (state_q.w_strb[1])
            state_d.analog.dac_second = state_q.w_data[15:8];
        end
        `DBM_OFF_ENABLE:
        begin
          // Writing bit 0 releases all digital routes
          if (state_q.w_strb[0] && state_q.w_data[0])
          begin
            for (int i = 0; i < `DBM_PIN_COUNT; i++)
              state_d.route[i].valid = 1'b0;
          end
        end
        `DBM_OFF_STATUS: state_d.axi.bresp = `DBM_RESP_OKAY;
        default: state_d.axi.bresp = `DBM_RESP_SLVERR;
      endcase
    end
    // Read channel
    if (state_q.axi.rvalid && s_axi_rready)
      state_d.axi.rvalid = 1'b0;
    if (s_axi_arvalid && !state_q.axi.arready && !state_q.axi.rvalid)
    begin
      state_d.axi.arready = 1'b1;
      state_d.axi.rvalid = 1'b1;
      state_d.axi.rresp = `DBM_RESP_OKAY;
      state_d.axi.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `DBM_OFF_DIGITAL: state_d.axi.rdata = {16'h0000, state_q.last_select, state_q.last_group};
        `DBM_OFF_ANALOG: state_d.axi.rdata = {16'h0000, state_q.analog.dac_second, state_q.analog.dac_first};
        `DBM_OFF_ENABLE: state_d.axi.rdata = {31'h0000_0000, testbus_on};
        `DBM_OFF_STATUS:
          state_d.axi.rdata = {20'h0_0000, state_q.pin_oe, pick_known, state_q.pin_out};
        default: state_d.axi.rresp = `DBM_RESP_SLVERR;
      endcase
    end
    // Pin drive: only enabled, valid and known routes reach a pin
    for (int i = 0; i < `DBM_PIN_COUNT; i++)
    begin
      state_d.pin_oe[i] = testbus_on && state_q.route[i].valid && pick_known[i];
      state_d.pin_out[i] = state_d.pin_oe[i] && pick_value[i];
    end
    // Analog converters feed the auxiliary pins when the test bus is on;
    // decoded from the next source code so enable never lags a switch to off
    state_d.ana_en[0] = testbus_on && (state_d.analog.dac_first != 8'h00);
    state_d.ana_en[1] = testbus_on && (state_d.analog.dac_second != 8'h00);
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.last_group <= `DBM_RST_GROUP;
      state_q.last_select <= `DBM_RST_SELECT;
      state_q.analog <= `DBM_RST_ANALOG;
      state_q.en_sync <= {2{`DBM_RST_ENABLE}};
    end
    else
      state_q <= state_d;
  end

  // Outputs straight from the state register
  assign s_axi_awready = state_q.axi.awready;
  assign s_axi_wready = state_q.axi.wready;
  assign s_axi_bvalid = state_q.axi.bvalid;
  assign s_axi_bresp = state_q.axi.bresp;
  assign s_axi_arready = state_q.axi.arready;
  assign s_axi_rvalid = state_q.axi.rvalid;
  assign s_axi_rdata = state_q.axi.rdata;
  assign s_axi_rresp = state_q.axi.rresp;
  assign debug_pin_out = state_q.pin_out;
  assign debug_pin_oe = state_q.pin_oe;
  assign analog_source_first = state_q.analog.dac_first;
  assign analog_source_second = state_q.analog.dac_second;
  assign analog_enable = state_q.ana_en;

endmodule
`default_nettype wire

// ### test/dbm_src_model.sv
/*
  Stand-in for the internal signal sources behind the debug multiplexer.
  Assumes the bench picks one source by bit index and a level for it.
*/
`timescale 1ns/1ps
`default_nettype none
module dbm_src_model
  import dbm_pkg::*;
(
  input wire logic [5:0] idx,
  input wire logic pol,
  output var dbm_sources_s sources
);
  localparam int W = $bits(dbm_sources_s);
  // Marked source at pol, all others inverse, so a wrong pick shows
  assign sources = pol ? dbm_sources_s'(W'(1) << idx) : dbm_sources_s'(~(W'(1) << idx));
endmodule
`default_nettype wire

// ### test/dbm_debug_mux_chk.sv
/*
  Concurrent checks on the ports of the debug multiplexer.
  Assumes one clock clk and asynchronous active-low reset_n.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbm_map.svh"
module dbm_debug_mux_chk
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic nv_testbus_enable,
  input wire logic [`DBM_PIN_COUNT-1:0] debug_pin_out,
  input wire logic [`DBM_PIN_COUNT-1:0] debug_pin_oe,
  input wire logic [7:0] analog_source_first,
  input wire logic [7:0] analog_source_second,
  input wire logic [1:0] analog_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Pin and converter outputs
  a_off_quiet: assert property (!nv_testbus_enable [*5] |-> debug_pin_oe == 4'h0 && analog_enable == 2'h0)
    else $error("debug output active while disabled");
  a_undriven_low: assert property ((debug_pin_out & ~debug_pin_oe) == 4'h0)
    else $error("undriven pin not low");
  a_first_src: assert property (analog_enable[0] |-> analog_source_first != 8'h00)
    else $error("first converter on without source");
  a_second_src: assert property (analog_enable[1] |-> analog_source_second != 8'h00)
    else $error("second converter on without source");
  // Register bus handshake
  a_bresp_time: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_r_with_ar: assert property ($rose(s_axi_rvalid) |-> s_axi_arready)
    else $error("read data without address");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {`DBM_RESP_OKAY, `DBM_RESP_SLVERR})
    else $error("bad write response code");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `DBM_RESP_SLVERR);
  c_pin: cover property (debug_pin_oe != 4'h0);
  c_analog: cover property (analog_enable == 2'h3);
endmodule
bind dbm_debug_mux dbm_debug_mux_chk u_chk (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .nv_testbus_enable(nv_testbus_enable), .debug_pin_out(debug_pin_out),
  .debug_pin_oe(debug_pin_oe), .analog_source_first(analog_source_first),
  .analog_source_second(analog_source_second), .analog_enable(analog_enable));
`default_nettype wire

// ### test/tb.sv
/*
  Self-checking bench of the debug multiplexer over its register bus.
  Assumes the source model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbm_map.svh"
module tb
  import dbm_pkg::*;
;
  logic clk, reset_n, awv, wv, bready, arv, rready, nv, pol, awr, wr, bv, arr, rv, kn;
  logic [3:0] awaddr, araddr, wstrb, pout, poe, c;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, aen;
  logic [7:0] a1, a2, b;
  logic [5:0] idx;
  dbm_sources_s src;
  int bad_count, n_tests;
  // Source bit index per code 7..0, FF where reserved; last group unknown
  logic [63:0] tbl [8] = '{64'h25262728292A2B2C, 64'hFFFFFFFFFFFF2324, 64'h201D211E221FFFFF,
    64'h1C1B1A1918171615, 64'h14131211100F0E0D, 64'h0C0B0A0908070605, 64'h0403FFFFFF020100, '1};
  logic [7:0] grp [8] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73, 8'h10};
  logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hF};
  dbm_src_model u_src (.idx(idx), .pol(pol), .sources(src));
  dbm_debug_mux u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .nv_testbus_enable(nv), .sources(src),
    .debug_pin_out(pout), .debug_pin_oe(poe), .analog_source_first(a1), .analog_source_second(a2),
    .analog_enable(aen));
  // Compares and counts
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Bus write: address and data offered together, response awaited
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      if (!ta && awr === 1'b1)
      begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (!tw && wr === 1'b1)
      begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    chk(bresp, er);
  endtask
  // Bus read with masked data compare
  task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    chk(rresp, er);
    chk(rdata & m, e);
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock of 5 ns period
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    #100000;
    bad_count++;
    wrap_up;
  end
  // Main sequence
  initial
  begin
    {reset_n, awv, wv, bready, arv, rready, nv, pol} = '0;
    {awaddr, araddr, wdata, idx} = '0;
    wstrb = 4'hF;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    axr(`DBM_OFF_STATUS, 32'h0, 32'hFFF, `DBM_RESP_OKAY);
    axr(`DBM_OFF_ENABLE, 32'h0, 32'h1, `DBM_RESP_OKAY);
    axw(`DBM_OFF_DIGITAL, 32'h0801, `DBM_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(poe, 4'h0);
    nv <= 1'b1;
    repeat (6) @(posedge clk);
    axr(`DBM_OFF_ENABLE, 32'h1, 32'h1, `DBM_RESP_OKAY);
    // Every group, codes 0 to 9 and F, pin from the code's low bits
    for (int g = 0; g < 8; g++)
      for (int k = 0; k < 11; k++)
      begin
        c = codes[k];
        b = c < 8 ? tbl[g][c*8 +: 8] : 8'hFF;
        kn = (b != 8'hFF) || (c == 4'h8 && g < 7);
        idx <= b != 8'hFF ? b[5:0] : 6'h2D;
        axw(`DBM_OFF_DIGITAL, {16'h0, 2'b00, c[1:0], c, grp[g]}, `DBM_RESP_OKAY);
        axw(`DBM_OFF_DIGITAL, {16'h0, 2'b00, c[1:0], c, grp[g]}, `DBM_RESP_OKAY);
        pol <= 1'b1;
        repeat (4) @(posedge clk);
        chk({poe[c[1:0]], pout[c[1:0]]}, {kn, kn});
        pol <= 1'b0;
        repeat (4) @(posedge clk);
        chk({poe[c[1:0]], pout[c[1:0]]}, {kn, 1'b0});
      end
    axw(`DBM_OFF_DIGITAL, 32'h4801, `DBM_RESP_SLVERR);
    axr(`DBM_OFF_DIGITAL, 32'h4801, 32'hFFFF, `DBM_RESP_OKAY);
    axr(4'h2, 32'h0, 32'h0, `DBM_RESP_SLVERR);
    axw(`DBM_OFF_ANALOG, 32'h0503, `DBM_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({a2, a1, aen}, {8'h05, 8'h03, 2'b11});
    axr(`DBM_OFF_ANALOG, 32'h0503, 32'hFFFF, `DBM_RESP_OKAY);
    axw(`DBM_OFF_ANALOG, 32'h0003, `DBM_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(aen, 2'b01);
    // Carrier on the primary and second auxiliary pins, then enable off and on, then clear
    idx <= 6'h2D;
    axw(`DBM_OFF_DIGITAL, 32'h0801, `DBM_RESP_OKAY);
    axw(`DBM_OFF_DIGITAL, 32'h2801, `DBM_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(poe, 4'h5);
    nv <= 1'b0;
    repeat (6) @(posedge clk);
    chk({poe, aen}, 6'h0);
    nv <= 1'b1;
    repeat (6) @(posedge clk);
    chk(poe, 4'h5);
    axw(`DBM_OFF_ENABLE, 32'h1, `DBM_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(poe, 4'h0);
    axr(`DBM_OFF_STATUS, 32'h0, 32'hF00, `DBM_RESP_OKAY);
    wrap_up;
  end
endmodule
`default_nettype wire
